// ==== logic/tws_pkg.sv ====
// shared constants and types for the two-wire setpoint port
package tws_pkg;

	// register pointer codes
	localparam logic [1:0] TWS_PTR_TEMP  = 2'h0;
	localparam logic [1:0] TWS_PTR_CFG   = 2'h1;
	localparam logic [1:0] TWS_PTR_HYSTERESIS_LIMIT = 2'h2;
	localparam logic [1:0] TWS_PTR_TOS   = 2'h3;

	// power-up values and setpoint fraction mask
	localparam logic [15:0] TWS_TOS_RESET   = 16'h5000;
	localparam logic [15:0] TWS_HYSTERESIS_LIMIT_RESET = 16'h4B00;
	localparam logic [7:0]  TWS_CFG_RESET   = 8'h00;
	localparam logic [7:0]  TWS_FRAC_MASK   = 8'hF0;

	// device-type code of the control byte; value is arbitrary
	localparam logic [3:0] TWS_DEV_TYPE = 4'h6;

	// control byte field positions
	localparam int TWS_RW_BIT  = 0;
	localparam int TWS_SEL_LSB = 1;
	localparam int TWS_TYP_LSB = 4;
	localparam int TWS_BYTE_BITS = 8;

	// bus clock timing
	localparam int TWS_REF_CLK_KHZ  = 25000;
	localparam int TWS_SCL_STD_KHZ  = 100;
	localparam int TWS_SCL_FAST_KHZ = 400;
	localparam int TWS_QUARTER_CYCLES = TWS_REF_CLK_KHZ / (4 * TWS_SCL_STD_KHZ);

	// controller register offsets
	localparam logic [7:0] TWS_REG_CMD    = 8'h00;
	localparam logic [7:0] TWS_REG_STATUS = 8'h04;
	localparam logic [7:0] TWS_REG_RXDATA = 8'h08;

	// controller command and status register fields
	localparam int TWS_CMD_DATA_LSB = 8;
	localparam int TWS_STAT_BUSY    = 0;
	localparam int TWS_STAT_ACK     = 1;

	typedef enum logic [2:0] {
		TWS_CMD_NOP       = 3'h0,
		TWS_CMD_START     = 3'h1,
		TWS_CMD_WRITE     = 3'h2,
		TWS_CMD_READ_ACK  = 3'h3,
		TWS_CMD_READ_NACK = 3'h4,
		TWS_CMD_STOP      = 3'h5
	} tws_cmd_t;

endpackage

// ==== logic/tws_link_if.sv ====
// open-drain two-wire link between controller and device
interface tws_link_if;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// wired-and with pull-up
	assign scl = !(scl_host_oe && !scl_host_o);
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

	modport device (
		input  scl,
		input  sda,
		output sda_dev_o,
		output sda_dev_oe
	);

	modport host (
		input  scl,
		input  sda,
		output scl_host_o,
		output scl_host_oe,
		output sda_host_o,
		output sda_host_oe
	);
endinterface

// ==== logic/tws_device.sv ====
// slave end of the two-wire port with setpoint and configuration storage
// Summary of operation
// - setpoints are 16-bit two's complement, low nibble zero
// - setpoint and config bits serve as general storage
// - master starts only on an idle bus
// - data changes only while clock low
// - data fall while clock high is start
// - data rise while clock high is stop
// - one clock pulse per bit, sampled high
// - msb first, eight bits plus acknowledge
// - works at standard and fast clock rates
// - acknowledger holds data low through ninth pulse
// - on master not-acknowledge, release data line
// - master answers last read byte with not-acknowledge
// - acknowledge every written data byte
// - repeated start ends and begins transfers
// - control byte holds type code and select bits
// - last control bit selects read or write
// - acknowledge control byte only on full match
// - hardware compare then receiver or transmitter
// - transmitter drives data on master clock
// - first written byte selects pointer, reset temperature
// - setpoints reset to eighty and seventy-five degrees
//
// The placing of the registers and the APB interface to the registers were decided locally.
module tws_device
	import tws_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = TWS_DEV_TYPE
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// link
	tws_link_if.device       link,
	// select straps
	input  wire logic        select_pin_bit0_i,
	input  wire logic        select_pin_bit1_i,
	input  wire logic        select_pin_bit2_i,
	// temperature from the conversion engine
	input  wire logic [15:0] temperature_i,
	// stored settings
	output logic      [15:0] over_temp_limit_o,
	output logic      [15:0] hysteresis_limit_o,
	output logic      [7:0]  cfg_o,
	output logic      [1:0]  pointer_o
);

	typedef enum logic [2:0] {
		DEV_IDLE   = 3'h0,
		DEV_ADDR   = 3'h1,
		DEV_WRITE  = 3'h2,
		DEV_ACK_RX = 3'h3,
		DEV_TX     = 3'h4,
		DEV_TX_ACK = 3'h5
	} tws_dev_state_t;

	typedef struct packed {
		logic           scl_s1;
		logic           scl_s2;
		logic           scl_prev;
		logic           sda_s1;
		logic           sda_s2;
		logic           sda_prev;
		logic [2:0]     sel_s1;
		logic [2:0]     sel_s2;
		tws_dev_state_t st;
		logic [3:0]     bit_cnt;
		logic [7:0]     shreg;
		logic           rw;
		logic [1:0]     byte_idx;
		logic [1:0]     pointer;
		logic [15:0]    over_temp_limit;
		logic [15:0]    hysteresis_limit;
		logic [7:0]     cfg_reg;
		logic           sda_o;
		logic           sda_oe;
	} tws_dev_q_t;

	localparam tws_dev_q_t DEV_RESET = '{
		scl_s1:           1'b1,
		scl_s2:           1'b1,
		scl_prev:         1'b1,
		sda_s1:           1'b1,
		sda_s2:           1'b1,
		sda_prev:         1'b1,
		sel_s1:           3'h0,
		sel_s2:           3'h0,
		st:               DEV_IDLE,
		bit_cnt:          4'h0,
		shreg:            8'h00,
		rw:               1'b0,
		byte_idx:         2'h0,
		pointer:          TWS_PTR_TEMP,
		over_temp_limit:  TWS_TOS_RESET,
		hysteresis_limit: TWS_HYSTERESIS_LIMIT_RESET,
		cfg_reg:          TWS_CFG_RESET,
		sda_o:            1'b0,
		sda_oe:           1'b0
	};

	localparam logic [3:0] LAST_BIT = 4'(TWS_BYTE_BITS);

	tws_dev_q_t q;
	tws_dev_q_t next_q;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic       addr_match;
	logic [15:0] rd_word;
	logic [7:0] tx_byte;

	always_comb begin
		scl_rise   = q.scl_s2 && !q.scl_prev;
		scl_fall   = !q.scl_s2 && q.scl_prev;
		start_cond = q.scl_s2 && q.scl_prev && q.sda_prev && !q.sda_s2;
		stop_cond  = q.scl_s2 && q.scl_prev && !q.sda_prev && q.sda_s2;
		addr_match = (q.shreg[7:TWS_TYP_LSB] == DEV_TYPE)
			&& (q.shreg[TWS_TYP_LSB-1:TWS_SEL_LSB] == q.sel_s2);
		unique case (q.pointer)
			TWS_PTR_TEMP:  rd_word = temperature_i;
			TWS_PTR_CFG:   rd_word = {q.cfg_reg, q.cfg_reg};
			TWS_PTR_HYSTERESIS_LIMIT: rd_word = q.hysteresis_limit;
			TWS_PTR_TOS:   rd_word = q.over_temp_limit;
		endcase
		tx_byte = q.byte_idx[0] ? rd_word[7:0] : rd_word[15:8];
	end

	always_comb begin
		next_q = q;
		// two-flop synchronisers, fast enough for both bus speeds
		next_q.scl_s1   = link.scl;
		next_q.scl_s2   = q.scl_s1;
		next_q.scl_prev = q.scl_s2;
		next_q.sda_s1   = link.sda;
		next_q.sda_s2   = q.sda_s1;
		next_q.sda_prev = q.sda_s2;
		next_q.sel_s1   = {select_pin_bit2_i, select_pin_bit1_i, select_pin_bit0_i};
		next_q.sel_s2   = q.sel_s1;
		if (start_cond) begin
			next_q.st       = DEV_ADDR;
			next_q.bit_cnt  = 4'h0;
			next_q.byte_idx = 2'h0;
			next_q.sda_oe   = 1'b0;
		end else if (stop_cond) begin
			next_q.st     = DEV_IDLE;
			next_q.sda_oe = 1'b0;
		end else begin
			unique case (q.st)
				DEV_IDLE: begin
					next_q.sda_oe = 1'b0;
				end
				DEV_ADDR, DEV_WRITE: begin
					if (scl_rise) begin
						next_q.shreg   = {q.shreg[6:0], q.sda_s2};
						next_q.bit_cnt = q.bit_cnt + 4'h1;
					end else if (scl_fall && q.bit_cnt == LAST_BIT) begin
						next_q.bit_cnt = 4'h0;
						if (q.st == DEV_ADDR) begin
							if (addr_match) begin
								next_q.rw     = q.shreg[TWS_RW_BIT];
								next_q.sda_oe = 1'b1;
								next_q.st     = DEV_ACK_RX;
							end else begin
								next_q.st = DEV_IDLE;
							end
						end else begin
							next_q.sda_oe = 1'b1;
							next_q.st     = DEV_ACK_RX;
							if (q.byte_idx != 2'h3) begin
								next_q.byte_idx = q.byte_idx + 2'h1;
							end
							unique case (q.byte_idx)
								2'h0: begin
									next_q.pointer = q.shreg[1:0];
								end
								2'h1: begin
									// storage usable as plain memory
									if (q.pointer == TWS_PTR_CFG) begin
										next_q.cfg_reg = q.shreg;
									end else if (q.pointer == TWS_PTR_HYSTERESIS_LIMIT) begin
										next_q.hysteresis_limit[15:8] = q.shreg;
									end else if (q.pointer == TWS_PTR_TOS) begin
										next_q.over_temp_limit[15:8] = q.shreg;
									end
								end
								2'h2: begin
									if (q.pointer == TWS_PTR_HYSTERESIS_LIMIT) begin
										next_q.hysteresis_limit[7:0] = q.shreg & TWS_FRAC_MASK;
									end else if (q.pointer == TWS_PTR_TOS) begin
										next_q.over_temp_limit[7:0] = q.shreg & TWS_FRAC_MASK;
									end
								end
								2'h3: begin
									next_q.byte_idx = 2'h3;
								end
							endcase
						end
					end
				end
				DEV_ACK_RX: begin
					if (scl_fall) begin
						if (q.rw) begin
							next_q.shreg       = tx_byte;
							next_q.sda_oe      = !tx_byte[7];
							next_q.byte_idx[0] = !q.byte_idx[0];
							next_q.st          = DEV_TX;
						end else begin
							next_q.sda_oe = 1'b0;
							next_q.st     = DEV_WRITE;
						end
					end
				end
				DEV_TX: begin
					if (scl_rise) begin
						next_q.bit_cnt = q.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (q.bit_cnt == LAST_BIT) begin
							next_q.bit_cnt = 4'h0;
							next_q.sda_oe  = 1'b0;
							next_q.st      = DEV_TX_ACK;
						end else begin
							next_q.shreg  = {q.shreg[6:0], 1'b0};
							next_q.sda_oe = !q.shreg[6];
						end
					end
				end
				DEV_TX_ACK: begin
					if (scl_rise) begin
						if (q.sda_s2) begin
							next_q.st = DEV_IDLE;
						end else begin
							next_q.bit_cnt = 4'h1;
						end
					end else if (scl_fall && q.bit_cnt == 4'h1) begin
						next_q.bit_cnt     = 4'h0;
						next_q.shreg       = tx_byte;
						next_q.sda_oe      = !tx_byte[7];
						next_q.byte_idx[0] = !q.byte_idx[0];
						next_q.st          = DEV_TX;
					end
				end
				default: begin
					next_q.st     = DEV_IDLE;
					next_q.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= DEV_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign link.sda_dev_o     = q.sda_o;
	assign link.sda_dev_oe    = q.sda_oe;
	assign over_temp_limit_o  = q.over_temp_limit;
	assign hysteresis_limit_o = q.hysteresis_limit;
	assign cfg_o              = q.cfg_reg;
	assign pointer_o          = q.pointer;

endmodule

// ==== logic/tws_host.sv ====
// bus master end of the two-wire port, commanded over apb
module tws_host
	import tws_pkg::*;
#(
	parameter int QUARTER_CYCLES = TWS_QUARTER_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// link
	tws_link_if.host         link
);

	typedef enum logic [1:0] {
		HST_IDLE  = 2'h0,
		HST_START = 2'h1,
		HST_BITS  = 2'h2,
		HST_STOP  = 2'h3
	} tws_hst_state_t;

	typedef struct packed {
		logic           scl_s1;
		logic           scl_s2;
		logic           sda_s1;
		logic           sda_s2;
		tws_hst_state_t st;
		logic [1:0]     phase;
		logic [3:0]     bit_cnt;
		logic [15:0]    div;
		logic [7:0]     shreg;
		logic           is_read;
		logic           send_ack;
		logic           ack_ok;
		logic [7:0]     rx_data;
		logic           scl_oe;
		logic           sda_oe;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} tws_hst_q_t;

	localparam tws_hst_q_t HST_RESET = '{
		scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
		st: HST_IDLE, phase: 2'h0, bit_cnt: 4'h0, div: 16'h0000,
		shreg: 8'h00, is_read: 1'b0, send_ack: 1'b0, ack_ok: 1'b0,
		rx_data: 8'h00, scl_oe: 1'b0, sda_oe: 1'b0,
		prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0
	};

	localparam logic [15:0] DIV_LAST = 16'(QUARTER_CYCLES - 1);

	tws_hst_q_t q;
	tws_hst_q_t next_q;
	logic       tick;
	logic       hold;
	logic       wr_cmd;
	tws_cmd_t   cmd;

	always_comb begin
		next_q = q;
		next_q.scl_s1 = link.scl;
		next_q.scl_s2 = q.scl_s1;
		next_q.sda_s1 = link.sda;
		next_q.sda_s2 = q.sda_s1;
		// apb: zero wait states, answer prepared in setup cycle
		next_q.pready  = psel_i && !penable_i;
		next_q.pslverr = 1'b0;
		next_q.prdata  = 32'h0000_0000;
		if (psel_i && !penable_i) begin
			if (paddr_i == TWS_REG_STATUS) begin
				next_q.prdata[TWS_STAT_BUSY] = q.st != HST_IDLE;
				next_q.prdata[TWS_STAT_ACK]  = q.ack_ok;
			end else if (paddr_i == TWS_REG_RXDATA) begin
				next_q.prdata[7:0] = q.rx_data;
			end else if (paddr_i != TWS_REG_CMD) begin
				next_q.pslverr = 1'b1;
			end
		end
		wr_cmd = psel_i && penable_i && q.pready && pwrite_i && paddr_i == TWS_REG_CMD;
		cmd    = tws_cmd_t'(pwdata_i[2:0]);
		// bit phases: quarter ticks, held while clock or bus not yet high
		hold = (q.phase == 2'h1) && (!q.scl_s2 || (q.st == HST_START && !q.sda_s2));
		tick = (q.st != HST_IDLE) && (q.div == DIV_LAST) && !hold;
		if (q.st != HST_IDLE && q.div != DIV_LAST) begin
			next_q.div = q.div + 16'h0001;
		end else if (tick) begin
			next_q.div = 16'h0000;
		end
		if (q.st == HST_IDLE && wr_cmd) begin
			next_q.phase   = 2'h0;
			next_q.bit_cnt = 4'h0;
			next_q.div     = 16'h0000;
			next_q.shreg   = pwdata_i[TWS_CMD_DATA_LSB +: 8];
			unique case (cmd)
				TWS_CMD_START: begin
					next_q.st     = HST_START;
					next_q.sda_oe = 1'b0;
				end
				TWS_CMD_WRITE: begin
					next_q.st      = HST_BITS;
					next_q.is_read = 1'b0;
					next_q.sda_oe  = !pwdata_i[TWS_CMD_DATA_LSB + 7];
				end
				TWS_CMD_READ_ACK, TWS_CMD_READ_NACK: begin
					next_q.st       = HST_BITS;
					next_q.is_read  = 1'b1;
					next_q.send_ack = cmd == TWS_CMD_READ_ACK;
					next_q.sda_oe   = 1'b0;
				end
				TWS_CMD_STOP: begin
					next_q.st     = HST_STOP;
					next_q.sda_oe = 1'b1;
				end
				default: begin
					next_q.st = HST_IDLE;
				end
			endcase
		end else if (tick) begin
			next_q.phase = q.phase + 2'h1;
			unique case (q.st)
				HST_START: begin
					if (q.phase == 2'h0) next_q.scl_oe = 1'b0;
					if (q.phase == 2'h1) next_q.sda_oe = 1'b1;
					if (q.phase == 2'h2) next_q.scl_oe = 1'b1;
					if (q.phase == 2'h3) next_q.st = HST_IDLE;
				end
				HST_BITS: begin
					if (q.phase == 2'h0) next_q.scl_oe = 1'b0;
					if (q.phase == 2'h1) begin
						if (q.bit_cnt == 4'h8) begin
							next_q.ack_ok = !q.sda_s2;
						end else begin
							next_q.shreg = {q.shreg[6:0], q.sda_s2};
						end
					end
					if (q.phase == 2'h2) next_q.scl_oe = 1'b1;
					if (q.phase == 2'h3) begin
						next_q.bit_cnt = q.bit_cnt + 4'h1;
						if (q.bit_cnt == 4'h8) begin
							next_q.st     = HST_IDLE;
							next_q.sda_oe = 1'b0;
							if (q.is_read) next_q.rx_data = q.shreg;
						end else if (q.bit_cnt == 4'h7) begin
							next_q.sda_oe = q.is_read && q.send_ack;
						end else begin
							next_q.sda_oe = !q.is_read && !q.shreg[7];
						end
					end
				end
				HST_STOP: begin
					if (q.phase == 2'h0) next_q.scl_oe = 1'b0;
					if (q.phase == 2'h1) next_q.sda_oe = 1'b0;
					if (q.phase == 2'h3) next_q.st = HST_IDLE;
				end
				default: begin
					next_q.st = HST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= HST_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign link.scl_host_o  = 1'b0;
	assign link.sda_host_o  = 1'b0;
	assign link.scl_host_oe = q.scl_oe;
	assign link.sda_host_oe = q.sda_oe;
	assign prdata_o         = q.prdata;
	assign pready_o         = q.pready;
	assign pslverr_o        = q.pslverr;

endmodule

// ==== sim/tws_chk.sv ====
// concurrent checks on the two-wire link between controller and device
module tws_chk
	import tws_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe,
	input wire logic sda_host_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic       ps, pd, first, match, rw, ack_slot, lead;
	logic [3:0] cnt;
	logic [7:0] sh;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	// ninth clock rise of a byte
	assign ack_slot = scl && !ps && cnt == 4'h8;

	// bit count, shifted byte and address outcome
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{ps, pd, first, match, rw} <= 5'h18;
			lead <= 1'b0;
			cnt <= 4'h0;
			sh  <= 8'h00;
		end else begin
			ps <= scl;
			pd <= sda;
			if (!scl && ps)
				lead <= 1'b0;
			if (scl && ps && pd && !sda) begin
				cnt   <= 4'h0;
				first <= 1'b1;
			end else if (scl && ps && !pd && sda) begin
				first <= 1'b0;
				match <= 1'b0;
			end else if (scl && !ps) begin
				cnt  <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
				lead <= (cnt == 4'h9);
				sh  <= {sh[6:0], sda};
				if (cnt == 4'h9)
					first <= 1'b0;
				if (ack_slot && first) begin
					match <= !sda;
					rw    <= sh[0];
				end
			end
		end
	end

	property p_dev_low_clk;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	a_dev_low_clk: assert property (p_dev_low_clk)
		else $error("device data moved while clock high");
	property p_type_miss;
		(ack_slot && first && sh[7:4] != TWS_DEV_TYPE) |-> sda;
	endproperty
	a_type_miss: assert property (p_type_miss)
		else $error("foreign control byte acknowledged");
	property p_wr_ack;
		(ack_slot && !first && match && !rw) |-> !sda [*4];
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("written byte not acknowledged");
	property p_ack_hold;
		(ack_slot && first && !sda) |-> !sda [*4];
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("acknowledge not held through clock high");
	property p_nack_release;
		(ack_slot && !first && match && rw && sda) |-> ##8 !sda_dev_oe [*8];
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("device drove data after not-acknowledge");
	property p_stop_idle;
		(scl && $past(scl) && $rose(sda)) |-> !sda_dev_oe [*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("device drove data after stop");
	property p_start_idle;
		(scl && $past(scl) && $fell(sda)) |-> !sda_dev_oe [*8];
	endproperty
	a_start_idle: assert property (p_start_idle)
		else $error("device drove data after start");
	// start and stop move data in the clock high before the first byte or after a whole byte
	property p_host_low_clk;
		($changed(sda_host_oe) && scl && $past(scl)) |-> (cnt == 4'h0 || cnt == 4'h9 || lead);
	endproperty
	a_host_low_clk: assert property (p_host_low_clk)
		else $error("controller data moved inside a byte while clock high");
	property p_unmatched_quiet;
		(!first && !match) |-> !sda_dev_oe;
	endproperty
	a_unmatched_quiet: assert property (p_unmatched_quiet)
		else $error("unaddressed device drove data");
endmodule

// ==== sim/tws_test.sv ====
// self-checking bench joining controller and device over the two-wire link
module tws_test
	import tws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, cfg, c;
	logic [31:0] pwdata, prdata, rdv;
	logic [2:0]  sel;
	logic [15:0] temp, otl, hyl, v;
	logic [1:0]  ptr;
	logic [63:0] expq[$];
	logic [63:0] ent;
	int          n_mismatch, checks_done;

	tws_link_if lnk();

	tws_host #(.QUARTER_CYCLES(4)) i_tws_host (
		.ref_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .link(lnk)
	);
	tws_device i_tws_device (
		.ref_clk_i(clk), .reset_n_i(rst_n), .link(lnk),
		.select_pin_bit0_i(sel[0]), .select_pin_bit1_i(sel[1]), .select_pin_bit2_i(sel[2]),
		.temperature_i(temp), .over_temp_limit_o(otl), .hysteresis_limit_o(hyl),
		.cfg_o(cfg), .pointer_o(ptr)
	);
	tws_chk i_tws_chk (
		.ref_clk_i(clk), .reset_n_i(rst_n), .scl(lnk.scl), .sda(lnk.sda),
		.sda_dev_oe(lnk.sda_dev_oe), .sda_host_oe(lnk.sda_host_oe)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// note the masked expectation, then read
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		expq.push_back({m, e});
		apb(1'b0, a, 32'h0000_0000, rdv);
	endtask

	// issue one link command and wait until idle
	task automatic cmd(input logic [2:0] k, input logic [7:0] b);
		apb(1'b1, TWS_REG_CMD, {16'h0000, b, 5'h00, k}, rdv);
		rdv = 32'h0000_0001;
		while (rdv[TWS_STAT_BUSY] !== 1'b0)
			rd(TWS_REG_STATUS, 32'h0000_0000, 32'h0000_0000);
	endtask

	task automatic wb(input logic [7:0] b, input logic ack);
		cmd(TWS_CMD_WRITE, b);
		rd(TWS_REG_STATUS, 32'h0000_0002, {30'h0000_0000, ack, 1'b0});
	endtask

	task automatic rb(input logic last, input logic [7:0] e);
		cmd(last ? TWS_CMD_READ_NACK : TWS_CMD_READ_ACK, 8'h00);
		rd(TWS_REG_RXDATA, 32'h0000_00ff, {24'h00_0000, e});
	endtask

	task automatic adr(input logic r);
		cmd(TWS_CMD_START, 8'h00);
		wb({TWS_DEV_TYPE, sel, r}, 1'b1);
	endtask

	// set the pointer, repeated start, read back one or two bytes
	task automatic rrd(input logic [7:0] p, input logic [15:0] x, input logic one);
		adr(1'b0);
		wb(p, 1'b1);
		adr(1'b1);
		rb(one, x[15:8]);
		if (!one)
			rb(1'b1, x[7:0]);
		cmd(TWS_CMD_STOP, 8'h00);
	endtask

	// compare each read result with the oldest note, when that note's mask is nonzero
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
			ent = expq.pop_front();
			if (ent[63:32] != 32'h0000_0000)
				check(prdata & ent[63:32], ent[31:0]);
		end
	end

	initial begin
		#(40 * 40000);
		n_mismatch++;
		summarize();
	end

	initial begin
		rdv = $urandom(32'h0000_2e02);
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sel = 3'($urandom);
		temp = 16'($urandom);
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check(32'(otl), 32'(TWS_TOS_RESET));
		check(32'(hyl), 32'(TWS_HYSTERESIS_LIMIT_RESET));
		check(32'(ptr), 32'(TWS_PTR_TEMP));
		check(32'(cfg), 32'(TWS_CFG_RESET));
		apb(1'b0, 8'h0c, 32'h0000_0000, rdv);
		check(32'(err), 32'h0000_0001);
		adr(1'b1);
		rb(1'b0, temp[15:8]);
		rb(1'b1, temp[7:0]);
		cmd(TWS_CMD_STOP, 8'h00);
		$display("test reset and default read done");
		for (int p = 2; p < 4; p++) begin
			v = 16'($urandom);
			adr(1'b0);
			wb(8'(p), 1'b1);
			wb(v[15:8], 1'b1);
			wb(v[7:0], 1'b1);
			cmd(TWS_CMD_STOP, 8'h00);
			v[3:0] = 4'h0;
			check(32'(p == 3 ? otl : hyl), 32'(v));
			rrd(8'(p), v, 1'b0);
		end
		$display("test setpoints done");
		c = 8'($urandom);
		adr(1'b0);
		wb(8'h01, 1'b1);
		wb(c, 1'b1);
		cmd(TWS_CMD_STOP, 8'h00);
		check(32'(cfg), 32'(c));
		rrd(8'h01, {c, 8'h00}, 1'b1);
		$display("test configuration done");
		for (int i = 0; i < 4; i++) begin
			cmd(TWS_CMD_START, 8'h00);
			wb({TWS_DEV_TYPE, sel, 1'b0} ^ (8'h02 << i), 1'b0);
			wb(8'h00, 1'b0);
			cmd(TWS_CMD_STOP, 8'h00);
			check(32'({lnk.scl, lnk.sda}), 32'h0000_0003);
			check(32'(ptr), 32'h0000_0001);
		end
		$display("test address mismatch done");
		summarize();
	end
endmodule
